// file: dv/testbench.sv
// Self-checking bench for the descriptor and frame logic
`timescale 1ns/1ps
module testbench;
   // ----------
   // Signals, model and design
   // ----------
   logic mclk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, desc_retire = 1'b0;
   logic xfer_serviced_flag = 1'b0, desc_writeback_flag = 1'b0, desc_is_iso = 1'b0;
   logic shared_area_wb_req = 1'b0, xfer_desc_req = 1'b0;
   logic [3:0] avs_address = 4'h0, hold_cycles = 4'h0;
   logic [31:0] avs_writedata = 32'h0, fetched_bus_word = 32'h0;
   logic [7:0] desc_word_load_strobe = 8'h00;
   logic [2:0] relative_frame_index = 3'h0;
   logic [31:4] retired_queue_head = 28'h0;
   usb_host_descriptor_frame_pkg::desc_writeback_t wb_info = '0;
   usb_host_descriptor_frame_pkg::master_cmd_t shared_area_cmd = '0, xfer_desc_cmd = '0;
   logic [31:0] avs_readdata, desc_word0, desc_word1, desc_word2, desc_word3;
   logic [31:0] iso_offset_status_pair, master_cycle_start_addr, master_write_bus;
   logic [14:0] payload_budget;
   logic avs_waitrequest, frame_start, shared_area_wb_ack, xfer_desc_ack, operational_state;
   logic bus_master_busy, ref_clk_12m, master_cycle_request;
   int checked = 0, miscompares = 0, t, p;
   usb_host_far_side_model i_usb_host_far_side_model (.*);
   usb_host_descriptor_frame_logic i_usb_host_descriptor_frame_logic (.*,
      .avs_byteenable(4'hF), .endpoint_desc_req(1'b0), .endpoint_desc_cmd('0),
      .endpoint_desc_ack(), .master_cycle_is_payload(),
      .master_cycle_is_read(), .master_cycle_bytes());
   initial begin
      forever #2 mclk = ~mclk;
   end
   task automatic stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge mclk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      #1;
      for (n = 0; avs_waitrequest !== 1'b0 && n < 20; n++) begin
         @(posedge mclk);
         #1;
      end
      q = avs_readdata;
      @(posedge mclk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n == 20) begin
         miscompares++;
         stop_test();
      end
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd
   task automatic ld(input int i, input logic [31:0] w);
      @(posedge mclk);
      fetched_bus_word <= w;
      desc_word_load_strobe <= 8'h01 << i;
      @(posedge mclk);
      desc_word_load_strobe <= 8'h00;
      #1;
   endtask : ld
   task automatic wb(input usb_host_descriptor_frame_pkg::desc_writeback_t i);
      @(posedge mclk);
      wb_info <= i;
      xfer_serviced_flag <= 1'b1;
      desc_writeback_flag <= 1'b1;
      @(posedge mclk);
      xfer_serviced_flag <= 1'b0;
      desc_writeback_flag <= 1'b0;
      #1;
   endtask : wb
   // Bounded wait: 0 frame start, 1 shared grant, 2 transfer grant
   task automatic wt(input int k);
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge mclk);
         #1;
         if ((k == 0 && frame_start === 1'b1) || (k == 1 && shared_area_wb_ack === 1'b1) ||
             (k == 2 && xfer_desc_ack === 1'b1)) break;
      end
      if (n == 400) begin
         miscompares++;
         stop_test();
      end
   endtask : wt
   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      rd(4'h0, 32'h0000_1000);
      wr(4'h4, 32'hFFFF_FFFF);
      rd(4'h4, 32'h0000_0000);
      rd(4'h3, 32'h0000_0000);
      wr(4'h0, 32'h8064_0003);
      rd(4'h0, 32'h8064_0003);
      $display("registers done");
      wr(4'h8, 32'h0000_0001);
      wt(0);
      chk({31'h0, operational_state}, 32'h1);
      chk({17'h0, payload_budget}, 32'h0000_0064);
      wt(0);
      t = $time;
      rd(4'h4, 32'h8000_0003);
      wt(0);
      p = ($time - t) / 4;
      chk(32'(p >= 81 && p <= 86), 32'h1);
      $display("frame timing done");
      ld(0, 32'h0123_4567);
      chk(desc_word0, 32'h0123_4567);
      ld(1, 32'h1111_1111);
      ld(2, 32'hFFFF_FFFF);
      chk(desc_word2, 32'hFFFF_FFF0);
      ld(3, 32'hABCD_EFFF);
      chk(desc_word3, 32'hABCD_E000);
      wb('{4'h9, 2'h2, 2'h1, 32'h2222_2222, 1'b0, 11'h0});
      chk(desc_word0, 32'h9923_4567);
      chk(desc_word1, 32'h2222_2222);
      chk(desc_word3, 32'hABCD_E000);
      wb('{4'h4, 2'h3, 2'h0, 32'h3333_3333, 1'b0, 11'h0});
      chk(desc_word1, 32'h2222_2222);
      @(posedge mclk);
      retired_queue_head <= 28'h765_4321;
      desc_retire <= 1'b1;
      @(posedge mclk);
      desc_retire <= 1'b0;
      #1;
      chk(desc_word2, 32'h7654_3210);
      desc_is_iso <= 1'b1;
      relative_frame_index <= 3'h1;
      ld(0, 32'h0200_0000);
      ld(4, 32'h5555_6666);
      chk(iso_offset_status_pair, 32'h5555_6666);
      ld(5, 32'h0000_0ABC);
      chk(desc_word3, 32'hABCD_EABC);
      wb('{4'h8, 2'h3, 2'h3, 32'h4444_4444, 1'b1, 11'h123});
      chk(iso_offset_status_pair, 32'h8123_6666);
      chk(desc_word0, 32'h8200_0000);
      chk(desc_word1, 32'h2222_2222);
      relative_frame_index <= 3'h2;
      ld(5, 32'h7777_8888);
      chk(desc_word3, 32'hABCD_EABC);
      wb('{4'h0, 2'h0, 2'h0, 32'h0, 1'b0, 11'h7FF});
      chk(iso_offset_status_pair, 32'h7777_0000);
      $display("descriptors done");
      hold_cycles <= 4'h6;
      shared_area_cmd <= '{1'b0, 1'b0, 8'h04, 32'hA000_0010, 32'h1234_5678};
      xfer_desc_cmd <= '{1'b1, 1'b1, 8'h10, 32'hB000_0020, 32'h0};
      shared_area_wb_req <= 1'b1;
      xfer_desc_req <= 1'b1;
      wt(1);
      chk({31'h0, xfer_desc_ack}, 32'h0);
      chk(master_cycle_start_addr, 32'hA000_0010);
      chk(master_write_bus, 32'h1234_5678);
      shared_area_wb_req <= 1'b0;
      wt(2);
      chk(master_cycle_start_addr, 32'hB000_0020);
      xfer_desc_req <= 1'b0;
      $display("arbiter done");
      stop_test();
   end
endmodule : testbench

// file: dv/usb_host_descriptor_frame_asserts.sv
// Port checker for the descriptor and frame logic
`timescale 1ns/1ps
module usb_host_descriptor_frame_asserts (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] fetched_bus_word,
   input wire logic [7:0] desc_word_load_strobe,
   input wire logic [31:0] desc_word0,
   input wire logic [31:0] desc_word3,
   input wire logic shared_area_wb_req,
   input wire logic bus_master_busy,
   input wire usb_host_descriptor_frame_pkg::master_cmd_t shared_area_cmd,
   input wire logic shared_area_wb_ack,
   input wire logic endpoint_desc_ack,
   input wire logic xfer_desc_ack,
   input wire logic master_cycle_request,
   input wire logic [31:0] master_cycle_start_addr
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   AST_WORD0_LOAD: assert property (desc_word_load_strobe[0] |=>
      desc_word0 == $past(fetched_bus_word)) else $error("word0 load wrong");
   AST_WORD3_LOAD: assert property (desc_word_load_strobe[3] |=> desc_word3 ==
      {$past(fetched_bus_word[31:12]), $past(fetched_bus_word[11:0]) + 12'h001})
      else $error("word3 load wrong");
   AST_WORD3_HOLD: assert property (!desc_word_load_strobe[3] &&
      !(|desc_word_load_strobe[7:5]) |=> $stable(desc_word3)) else $error("word3 moved");
   AST_SHARED_GRANT: assert property ($rose(shared_area_wb_ack) |-> $past(
      shared_area_wb_req && !endpoint_desc_ack && !xfer_desc_ack && !bus_master_busy))
      else $error("shared grant out of turn");
   AST_LOW_GRANT: assert property ($rose(endpoint_desc_ack || xfer_desc_ack) |->
      $past(!shared_area_wb_req && !bus_master_busy)) else $error("low grant out of turn");
   AST_PULSE_ONE: assert property ($rose(shared_area_wb_ack || endpoint_desc_ack ||
      xfer_desc_ack) |-> master_cycle_request ##1 !master_cycle_request)
      else $error("cycle request not one clock");
   AST_PULSE_CAUSE: assert property (master_cycle_request |-> $rose(
      shared_area_wb_ack || endpoint_desc_ack || xfer_desc_ack)) else $error("stray request");
   AST_ROUTE: assert property ($rose(shared_area_wb_ack) |->
      master_cycle_start_addr == $past(shared_area_cmd.start_addr)) else $error("bad route");
endmodule : usb_host_descriptor_frame_asserts
bind usb_host_descriptor_frame_logic usb_host_descriptor_frame_asserts i_asserts (.*);

// file: dv/usb_host_far_side_model.sv
// Bus master and reference clock model for the descriptor and frame logic
`timescale 1ns/1ps
module usb_host_far_side_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic master_cycle_request,
   input wire logic [3:0] hold_cycles,
   output logic bus_master_busy,
   output logic ref_clk_12m
);
   logic [3:0] left;
   initial begin
      ref_clk_12m = 1'b0;
      forever #41.667 ref_clk_12m = ~ref_clk_12m;
   end
   // Busy for hold_cycles clocks after each granted cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         left <= 4'h0;
      end else if (master_cycle_request) begin
         left <= hold_cycles;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign bus_master_busy = (left != 4'h0);
endmodule : usb_host_far_side_model

// file: hdl/usb_host_descriptor_frame_logic.sv
// Descriptor holding words, bus master arbiter and frame timing of the USB host list processor
//
// Operation
// RULE_01: General status word: outcome 31-28, retries 27-26, toggle 25-24, delay, direction.
// RULE_02: Outcome codes: 0000 no fault, 1000 payload excess, 1001 payload short.
// RULE_03: Five 32-bit holding words, shared by both descriptor kinds, not software visible.
// RULE_04: Isochronous status word: outcome 31-28, span 26-24, delay 23-21, first frame.
// RULE_05: Strobe index 0 loads the full fetched word into status word zero.
// RULE_06: On serviced writeback update outcome, retries, toggle; isochronous only outcome.
// RULE_07: Word one holds buffer page and offset; loaded on strobe index 1.
// RULE_08: Buffer pointer written back only for general, serviced, good or excess/short.
// RULE_09: Word two link loaded from bits 31-4; retire overwrites with queue head.
// RULE_10: Strobe 3 loads end page and end offset plus one.
// RULE_11: Odd isochronous index not equal span stores next offset via strobes 5-7.
// RULE_12: Word three never changes on writeback, only through its loads.
// RULE_13: Even index: current offset low, next high; odd: current high, next spare.
// RULE_14: Offset pair loads on strobe index four plus half the relative frame.
// RULE_15: Isochronous writeback rewrites only current half with outcome and byte count.
// RULE_16: Shared area writeback has top priority when no other grant and master idle.
// RULE_17: Endpoint or transfer grant only with shared request low and master idle.
// RULE_18: Master cycle request pulses one clock when a submaster is granted.
// RULE_19: Granted submaster's control and write data route to the bus master.
// RULE_20: Register read data multiplexed onto the slave read bus by address decode.
// RULE_21: Frame start copies frame length and period marker into the countdown.
// RULE_22: Frame start loads the payload budget counter from the programmed maximum.
// RULE_23: Countdown is 14 bits, one step per bit time, valid while operational.
// RULE_24: At zero the countdown reloads on the next 12 MHz reference edge.
// RULE_25: Entering operational state reloads the countdown.
// RULE_26: Software inverts the period marker whenever it programs a new length.
// RULE_27: Countdown and marker can be read any time without disturbing them.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "usb_host_descriptor_frame_defines.svh"

module usb_host_descriptor_frame_logic #(
   parameter int LENGTH_WIDTH = 14,
   parameter int BUDGET_WIDTH = 15
) (
   input wire logic mclk,
   input wire logic resetn,
   // Avalon-MM register slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // 12 MHz reference pin and frame timing outputs
   input wire logic ref_clk_12m,
   output logic frame_start,
   output logic operational_state,
   output logic [BUDGET_WIDTH-1:0] payload_budget,
   // Descriptor loading and writeback
   input wire logic [31:0] fetched_bus_word,
   input wire logic [7:0] desc_word_load_strobe,
   input wire logic desc_is_iso,
   input wire logic [2:0] relative_frame_index,
   input wire logic xfer_serviced_flag,
   input wire logic desc_writeback_flag,
   input wire logic desc_retire,
   input wire logic [31:4] retired_queue_head,
   input wire usb_host_descriptor_frame_pkg::desc_writeback_t wb_info,
   output logic [31:0] desc_word0,
   output logic [31:0] desc_word1,
   output logic [31:0] desc_word2,
   output logic [31:0] desc_word3,
   output logic [31:0] iso_offset_status_pair,
   // Bus master arbitration
   input wire logic shared_area_wb_req,
   input wire logic endpoint_desc_req,
   input wire logic xfer_desc_req,
   input wire logic bus_master_busy,
   input wire usb_host_descriptor_frame_pkg::master_cmd_t shared_area_cmd,
   input wire usb_host_descriptor_frame_pkg::master_cmd_t endpoint_desc_cmd,
   input wire usb_host_descriptor_frame_pkg::master_cmd_t xfer_desc_cmd,
   output logic shared_area_wb_ack,
   output logic endpoint_desc_ack,
   output logic xfer_desc_ack,
   output logic master_cycle_request,
   output logic master_cycle_is_payload,
   output logic master_cycle_is_read,
   output logic [7:0] master_cycle_bytes,
   output logic [31:0] master_cycle_start_addr,
   output logic [31:0] master_write_bus
);

   // ----------
   // Functions
   // ----------
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                               input logic [31:0] new_value,
                                               input logic [3:0] lanes);
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            result[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return result;
   endfunction : merge_bytes

   function automatic logic good_outcome(input logic [3:0] code);
      return (code == `OUTCOME_NO_FAULT) || (code == `OUTCOME_PAYLOAD_EXCESS) ||
             (code == `OUTCOME_PAYLOAD_SHORT);
   endfunction : good_outcome

   // ----------
   // Avalon slave
   // ----------
   logic bus_done;
   logic [31:0] frame_period_setting;
   logic host_run;
   logic [LENGTH_WIDTH-1:0] bit_times_left;
   logic active_period_marker;
   logic [31:0] slave_read_bus;

   wire bus_access = avs_read | avs_write;
   wire write_commit = avs_write & bus_done;
   wire hit_period = (avs_address == `OFS_FRAME_PERIOD_SETTING);
   wire hit_countdown = (avs_address == `OFS_FRAME_COUNTDOWN_STATUS);
   wire hit_run = (avs_address == `OFS_HOST_RUN_CONTROL);
   wire hit_budget = (avs_address == `OFS_PAYLOAD_BUDGET_STATUS);
   wire [31:0] countdown_word = {active_period_marker,
                                 {(31 - LENGTH_WIDTH){1'b0}}, bit_times_left};
   wire [31:0] run_word = {31'h0000_0000, host_run};
   wire [31:0] budget_word = {{(32 - BUDGET_WIDTH){1'b0}}, payload_budget};
   wire [31:0] merged_period = merge_bytes(frame_period_setting, avs_writedata, avs_byteenable);
   wire [31:0] merged_run = merge_bytes(run_word, avs_writedata, avs_byteenable);

   // Read mux, unmapped reads as zero
   always_comb begin
      if (hit_period) begin
         slave_read_bus = frame_period_setting; // RULE_20
      end else if (hit_countdown) begin
         slave_read_bus = countdown_word; // RULE_27
      end else if (hit_run) begin
         slave_read_bus = run_word;
      end else if (hit_budget) begin
         slave_read_bus = budget_word;
      end else begin
         slave_read_bus = 32'h0000_0000;
      end
   end

   assign avs_waitrequest = bus_access & ~bus_done;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_done <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         bus_done <= bus_access & ~bus_done;
         if (avs_read && !bus_done) begin
            avs_readdata <= slave_read_bus; // RULE_20
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         frame_period_setting <= `FPS_RESET;
         host_run <= 1'b0;
      end else if (write_commit) begin
         if (hit_period) begin
            frame_period_setting <= merged_period;
         end
         if (hit_run) begin
            host_run <= merged_run[`RUN_OPERATIONAL_BIT];
         end
      end
   end

   // ----------
   // Frame countdown
   // ----------
   logic ref_meta;
   logic ref_sync;
   logic ref_prev;
   logic run_prev;
   logic [2:0] stuff_phase;

   wire ref_edge = ref_sync & ~ref_prev;
   wire enter_operational = host_run & ~run_prev;
   wire [LENGTH_WIDTH-1:0] frame_length_bits = frame_period_setting[`FPS_LENGTH_MSB:0];
   wire period_change_marker = frame_period_setting[`FPS_MARKER_BIT];
   wire [BUDGET_WIDTH-1:0] max_fullspeed_payload_bits =
      frame_period_setting[`FPS_MAXPAY_MSB:`FPS_MAXPAY_LSB];
   wire countdown_zero = (bit_times_left == '0);
   wire frame_reload = enter_operational | (host_run & ref_edge & countdown_zero); // RULE_24
   wire bit_step = host_run & ref_edge & ~countdown_zero;
   wire [LENGTH_WIDTH-1:0] next_bit_times_left = bit_times_left - LENGTH_WIDTH'(1);
   wire [2:0] next_stuff_phase = (stuff_phase == `STUFF_PERIOD_BITS - 3'h1) ? 3'h0 :
                                 stuff_phase + 3'h1;
   wire budget_step = bit_step & (payload_budget != '0) &
                      (stuff_phase != `STUFF_PERIOD_BITS - 3'h1);

   assign operational_state = host_run;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         ref_meta <= ref_clk_12m;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
         run_prev <= host_run;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bit_times_left <= '0;
         active_period_marker <= 1'b0;
         frame_start <= 1'b0;
      end else begin
         frame_start <= frame_reload;
         if (frame_reload) begin
            bit_times_left <= frame_length_bits; // RULE_21 RULE_25
            active_period_marker <= period_change_marker; // RULE_21 RULE_26
         end else if (bit_step) begin
            bit_times_left <= next_bit_times_left; // RULE_23
         end
      end
   end

   // Payload budget drops six of every seven bit times to model stuffing
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         payload_budget <= '0;
         stuff_phase <= 3'h0;
      end else if (frame_reload) begin
         payload_budget <= max_fullspeed_payload_bits; // RULE_22
         stuff_phase <= 3'h0;
      end else if (bit_step) begin
         stuff_phase <= next_stuff_phase;
         if (budget_step) begin
            payload_budget <= payload_budget - BUDGET_WIDTH'(1);
         end
      end
   end

   // ----------
   // Descriptor holding words
   // ----------
   wire writeback_now = xfer_serviced_flag & desc_writeback_flag;
   wire frame_is_odd = relative_frame_index[0];
   wire [2:0] span = desc_word0[`W0_ISO_SPAN_MSB:`W0_ISO_SPAN_LSB];
   wire [2:0] pair_strobe_index = 3'h4 + {1'b0, relative_frame_index[2:1]};
   wire pair_load = desc_word_load_strobe[pair_strobe_index]; // RULE_14
   wire spare_load = desc_is_iso & (relative_frame_index != span) &
                     ((desc_word_load_strobe[5] & (relative_frame_index == 3'h1)) |
                      (desc_word_load_strobe[6] & (relative_frame_index == 3'h3)) |
                      (desc_word_load_strobe[7] & (relative_frame_index == 3'h5)));
   wire [11:0] end_offset_plus1 = fetched_bus_word[`OFFSET_MSB:0] + 12'h001;
   wire [15:0] packet_status = {wb_info.outcome_code, 1'b0,
                                wb_info.packet_is_in ? wb_info.received_bytes : 11'h000};

   // Word zero: status, loaded whole, outcome fields rewritten on writeback
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         desc_word0 <= 32'h0000_0000;
      end else if (desc_word_load_strobe[0]) begin
         desc_word0 <= fetched_bus_word; // RULE_03 RULE_05
      end else if (writeback_now) begin
         desc_word0[`W0_OUTCOME_MSB:`W0_OUTCOME_LSB] <= wb_info.outcome_code; // RULE_01 RULE_04
         if (!desc_is_iso) begin
            desc_word0[`W0_RETRY_MSB:`W0_RETRY_LSB] <= wb_info.retry_error_tally; // RULE_06
            desc_word0[`W0_TOGGLE_MSB:`W0_TOGGLE_LSB] <= wb_info.toggle_sequence_bits; // RULE_06
         end
      end
   end

   // Word one: buffer pointer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         desc_word1 <= 32'h0000_0000;
      end else if (desc_word_load_strobe[1]) begin
         desc_word1 <= fetched_bus_word; // RULE_07
      end else if (writeback_now && !desc_is_iso && good_outcome(wb_info.outcome_code)) begin
         desc_word1 <= wb_info.new_buf_pointer; // RULE_02 RULE_08
      end
   end

   // Word two: link, replaced by queue head on retirement
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         desc_word2 <= 32'h0000_0000;
      end else if (desc_word_load_strobe[2]) begin
         desc_word2 <= {fetched_bus_word[31:`LINK_LSB], 4'h0}; // RULE_09
      end else if (desc_retire) begin
         desc_word2 <= {retired_queue_head, 4'h0}; // RULE_09
      end
   end

   // Word three: end pointer; low field doubles as spare offset, no writeback path
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         desc_word3 <= 32'h0000_0000;
      end else if (desc_word_load_strobe[3]) begin
         desc_word3 <= {fetched_bus_word[`PAGE_MSB:`PAGE_LSB], end_offset_plus1}; // RULE_10 RULE_12
      end else if (spare_load) begin
         desc_word3[`OFFSET_MSB:0] <= fetched_bus_word[`OFFSET_MSB:0]; // RULE_11 RULE_13
      end
   end

   // Offset pair: only the current frame's half is rewritten
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         iso_offset_status_pair <= 32'h0000_0000;
      end else if (pair_load) begin
         iso_offset_status_pair <= fetched_bus_word; // RULE_13 RULE_14
      end else if (writeback_now && desc_is_iso) begin
         if (frame_is_odd) begin
            iso_offset_status_pair[31:`PAIR_HIGH_LSB] <= packet_status; // RULE_15
         end else begin
            iso_offset_status_pair[`PAIR_LOW_MSB:0] <= packet_status; // RULE_15
         end
      end
   end

   // ----------
   // Bus master arbitration and muxing
   // ----------
   usb_host_descriptor_frame_pkg::bus_owner_t owner;
   usb_host_descriptor_frame_pkg::master_cmd_t chosen_cmd;

   wire any_ack = shared_area_wb_ack | endpoint_desc_ack | xfer_desc_ack;
   wire next_shared_ack = shared_area_wb_req &
                          (shared_area_wb_ack | (~endpoint_desc_ack & ~xfer_desc_ack &
                                                 ~bus_master_busy)); // RULE_16
   wire lower_free = ~shared_area_wb_req & ~bus_master_busy & ~any_ack;
   wire next_endpoint_ack = endpoint_desc_req & (endpoint_desc_ack | lower_free); // RULE_17
   wire next_xfer_ack = xfer_desc_req & ~endpoint_desc_req &
                        (xfer_desc_ack | lower_free); // RULE_17
   wire new_grant = (next_shared_ack & ~shared_area_wb_ack) |
                    (next_endpoint_ack & ~endpoint_desc_ack) |
                    (next_xfer_ack & ~xfer_desc_ack);

   always_comb begin
      if (next_shared_ack) begin
         owner = usb_host_descriptor_frame_pkg::OWNER_SHARED_AREA;
         chosen_cmd = shared_area_cmd;
      end else if (next_endpoint_ack) begin
         owner = usb_host_descriptor_frame_pkg::OWNER_ENDPOINT;
         chosen_cmd = endpoint_desc_cmd;
      end else if (next_xfer_ack) begin
         owner = usb_host_descriptor_frame_pkg::OWNER_XFER;
         chosen_cmd = xfer_desc_cmd;
      end else begin
         owner = usb_host_descriptor_frame_pkg::OWNER_NONE;
         chosen_cmd = '0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shared_area_wb_ack <= 1'b0;
         endpoint_desc_ack <= 1'b0;
         xfer_desc_ack <= 1'b0;
         master_cycle_request <= 1'b0;
      end else begin
         shared_area_wb_ack <= next_shared_ack;
         endpoint_desc_ack <= next_endpoint_ack;
         xfer_desc_ack <= next_xfer_ack;
         master_cycle_request <= new_grant; // RULE_18
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         master_cycle_is_payload <= 1'b0;
         master_cycle_is_read <= 1'b0;
         master_cycle_bytes <= 8'h00;
         master_cycle_start_addr <= 32'h0000_0000;
         master_write_bus <= 32'h0000_0000;
      end else if (owner != usb_host_descriptor_frame_pkg::OWNER_NONE) begin
         master_cycle_is_payload <= chosen_cmd.is_payload; // RULE_19
         master_cycle_is_read <= chosen_cmd.is_read; // RULE_19
         master_cycle_bytes <= chosen_cmd.bytes; // RULE_19
         master_cycle_start_addr <= chosen_cmd.start_addr; // RULE_19
         master_write_bus <= chosen_cmd.write_data; // RULE_19
      end
   end

endmodule : usb_host_descriptor_frame_logic

// file: include/usb_host_descriptor_frame_defines.svh
// Offsets, field positions, reset values and timing counts of the descriptor and frame logic
`ifndef USB_HOST_DESCRIPTOR_FRAME_DEFINES_SVH
`define USB_HOST_DESCRIPTOR_FRAME_DEFINES_SVH

// ----------
// Register byte offsets
// ----------
`define OFS_FRAME_PERIOD_SETTING 4'h0
`define OFS_FRAME_COUNTDOWN_STATUS 4'h4
`define OFS_HOST_RUN_CONTROL 4'h8
`define OFS_PAYLOAD_BUDGET_STATUS 4'hC

// ----------
// Register fields
// ----------
`define FPS_LENGTH_MSB 13
`define FPS_MAXPAY_LSB 16
`define FPS_MAXPAY_MSB 30
`define FPS_MARKER_BIT 31
`define FPS_RESET 32'h0000_1000
`define RUN_OPERATIONAL_BIT 0

// ----------
// Descriptor word fields
// ----------
`define W0_OUTCOME_MSB 31
`define W0_OUTCOME_LSB 28
`define W0_RETRY_MSB 27
`define W0_RETRY_LSB 26
`define W0_TOGGLE_MSB 25
`define W0_TOGGLE_LSB 24
`define W0_IRQ_DELAY_MSB 23
`define W0_IRQ_DELAY_LSB 21
`define W0_DIR_MSB 20
`define W0_DIR_LSB 19
`define W0_ISO_SPAN_MSB 26
`define W0_ISO_SPAN_LSB 24
`define W0_ISO_FIRST_MSB 15
`define W0_ISO_FIRST_LSB 0
`define PAGE_MSB 31
`define PAGE_LSB 12
`define OFFSET_MSB 11
`define LINK_LSB 4
`define PAIR_LOW_MSB 15
`define PAIR_HIGH_LSB 16

// ----------
// Outcome codes
// ----------
`define OUTCOME_NO_FAULT 4'h0
`define OUTCOME_PAYLOAD_EXCESS 4'h8
`define OUTCOME_PAYLOAD_SHORT 4'h9

// ----------
// Timing
// ----------
`define REF_CLOCK_MHZ 12
`define STUFF_PERIOD_BITS 3'h7
`define DESC_WORD_COUNT 5

`endif

// file: include/usb_host_descriptor_frame_pkg.sv
// Types shared by the descriptor and frame logic
package usb_host_descriptor_frame_pkg;

   typedef enum logic [1:0] {
      OWNER_NONE = 2'b00,
      OWNER_SHARED_AREA = 2'b01,
      OWNER_ENDPOINT = 2'b10,
      OWNER_XFER = 2'b11
   } bus_owner_t;

   typedef struct packed {
      logic is_payload;
      logic is_read;
      logic [7:0] bytes;
      logic [31:0] start_addr;
      logic [31:0] write_data;
   } master_cmd_t;

   typedef struct packed {
      logic [3:0] outcome_code;
      logic [1:0] retry_error_tally;
      logic [1:0] toggle_sequence_bits;
      logic [31:0] new_buf_pointer;
      logic packet_is_in;
      logic [10:0] received_bytes;
   } desc_writeback_t;

endpackage : usb_host_descriptor_frame_pkg
